// file: design/pbs_regs.svh
// constants for the pipelined burst sram port and its controller
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH
`define PBS_ADDR_W 17
`define PBS_DATA_W 32
`define PBS_PAR_W 4
`define PBS_LANES 4
`define PBS_BURST_W 2
`define PBS_CLK_MHZ 125
// sleep entry/exit takes two cycles
`define PBS_SLEEP_CYC 2
`endif

// file: design/pbs_pkg.sv
// types used by the device end of the burst sram port
package pbs_pkg;
  typedef enum logic [1:0] {
    PBS_OP_IDLE = 2'h0,
    PBS_OP_READ = 2'h1,
    PBS_OP_WRITE = 2'h2
  } pbs_op_t;
endpackage

// file: design/pbs_if.sv
// pin bundle between the sram device and its memory controller
`timescale 1ns/1ns
`default_nettype none
`include "pbs_regs.svh"
interface pbs_if;
  logic [`PBS_ADDR_W-1:0] addr;
  logic clock_qualify_n;
  logic select_one_n;
  logic select_two;
  logic select_three_n;
  logic writeEn_n;
  logic [`PBS_LANES-1:0] byte_lane_write_n;
  logic advance_or_load;
  logic outEnable_n;
  logic sleep_request;
  logic burstMode;
  logic [`PBS_DATA_W-1:0] dqCtl;
  logic dqCtlOe;
  logic [`PBS_PAR_W-1:0] parCtl;
  logic [`PBS_DATA_W-1:0] dqDev;
  logic dqDevOe;
  logic [`PBS_PAR_W-1:0] parDev;
  wire [`PBS_DATA_W-1:0] dqBus;
  wire [`PBS_PAR_W-1:0] parity_lines;
  assign dqBus = dqDevOe ? dqDev : (dqCtlOe ? dqCtl : '0);
  assign parity_lines = dqDevOe ? parDev : (dqCtlOe ? parCtl : '0);
  modport device (
    input addr, clock_qualify_n, select_one_n, select_two,
    input select_three_n, writeEn_n, byte_lane_write_n, advance_or_load,
    input outEnable_n, sleep_request, burstMode, dqBus, parity_lines,
    output dqDev, dqDevOe, parDev
  );
  modport ctrl (
    output addr, clock_qualify_n, select_one_n, select_two,
    output select_three_n, writeEn_n, byte_lane_write_n, advance_or_load,
    output outEnable_n, sleep_request, burstMode, dqCtl, dqCtlOe, parCtl,
    input dqBus, parity_lines
  );
endinterface
`default_nettype wire

// file: design/pbs_sram_dev.sv
// synchronous pipelined burst sram, 128K x 36, device end of the port
// Behaviour
// (RULE1) inputs captured in registers at clock rise
// (RULE2) read data leaves through output registers
// (RULE3) high clock qualify freezes all state
// (RULE4) low byte selects with write pick lanes
// (RULE5) select needs one low, two high, three low
// (RULE6) registered address picks word, loads counter
// (RULE7) write enable sampled only on qualified edges
// (RULE8) advance steps counter, load takes address
// (RULE9) controller loads fresh address after deselect
// (RULE10) output enable low lets data pins drive
// (RULE11) float on write, deselect, first cycle after
// (RULE12) input data captured; outputs carry read word
// (RULE13) parity lanes behave like data lanes
// (RULE14) strap low linear, high interleaved order
// (RULE15) sleep input keeps data, holds accesses
// (RULE16) back-to-back reads and writes, no waits
// (RULE17) writes self-timed from synchronous inputs
// (RULE18) read word appears one edge after address
// (RULE19) write data latched second edge after address
// (RULE20) burst counter wraps after four accesses
// (RULE21) burst keeps type, ignores selects and write
// (RULE22) deselect float follows read pipeline delay
`timescale 1ns/1ns
`default_nettype none
`include "pbs_regs.svh"
module pbs_sram_dev #(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int DATA_W = `PBS_DATA_W,
  parameter int LANES = `PBS_LANES
) (
  input wire logic ref_clk, // core clock
  input wire logic rstn, // sync reset, models power-up only
  pbs_if.device bus // sram pins
);
  localparam int LW = DATA_W / LANES;
  localparam int WORDS = 1 << ADDR_W;
  localparam int WL = LW + 1; // byte plus its parity bit

  logic [LANES*WL-1:0] mem [WORDS];
  logic [ADDR_W-1:0] baseAddr_reg;
  logic [1:0] burstCnt_reg;
  pbs_pkg::pbs_op_t op_reg; // access latched in the address stage
  pbs_pkg::pbs_op_t dataOp_reg; // access in the data stage
  logic [ADDR_W-1:0] dataAddr_reg;
  logic [LANES-1:0] laneAd_reg; // byte selects of the address stage
  logic [LANES-1:0] laneWr_reg;
  logic [1:0] lowAddr;
  logic [DATA_W-1:0] rdData_reg;
  logic [LANES-1:0] rdPar_reg;
  logic [1:0] sleepSync_reg;
  logic [1:0] burstCnt_next;
  logic [ADDR_W-1:0] curAddr;
  logic clkOn;
  logic selected;

  // sleep is asynchronous: two flops also give the two-cycle entry
  always_ff @(posedge ref_clk) begin
    if (!rstn) sleepSync_reg <= 2'h0;
    else sleepSync_reg <= {sleepSync_reg[0], bus.sleep_request};
  end

  assign clkOn = !bus.clock_qualify_n && !sleepSync_reg[1]; // RULE3 RULE15
  assign selected = !bus.select_one_n && bus.select_two
                    && !bus.select_three_n; // RULE5

  // the counter holds the burst step; order is applied to the base bits
  always_comb begin
    burstCnt_next = burstCnt_reg + 2'h1; // RULE20
  end

  assign lowAddr = bus.burstMode ? (baseAddr_reg[1:0] ^ burstCnt_reg)
                                 : (baseAddr_reg[1:0] + burstCnt_reg); // RULE14
  assign curAddr = {baseAddr_reg[ADDR_W-1:2], lowAddr}; // RULE6

  // address stage: load or advance
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      baseAddr_reg <= '0;
      burstCnt_reg <= 2'h0;
      laneAd_reg <= '0;
      op_reg <= pbs_pkg::PBS_OP_IDLE;
    end else if (clkOn) begin // RULE3
      laneAd_reg <= ~bus.byte_lane_write_n; // RULE4
      if (!bus.advance_or_load) begin // RULE8
        baseAddr_reg <= bus.addr; // RULE1 RULE6
        burstCnt_reg <= 2'h0;
        if (!selected) op_reg <= pbs_pkg::PBS_OP_IDLE; // RULE22
        else if (!bus.writeEn_n) op_reg <= pbs_pkg::PBS_OP_WRITE; // RULE7
        else op_reg <= pbs_pkg::PBS_OP_READ;
      end else if (op_reg != pbs_pkg::PBS_OP_IDLE) begin
        burstCnt_reg <= burstCnt_next; // RULE20 RULE21
      end
    end
  end

  // data stage follows the address stage by one qualified edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dataOp_reg <= pbs_pkg::PBS_OP_IDLE;
      dataAddr_reg <= '0;
      laneWr_reg <= '0;
    end else if (clkOn) begin
      dataOp_reg <= op_reg; // RULE16 RULE22
      dataAddr_reg <= curAddr;
      laneWr_reg <= laneAd_reg; // RULE4
    end
  end

  // self-timed write: data and parity caught on the second edge
  generate
    for (genvar l = 0; l < LANES; l++) begin : gLane
      always_ff @(posedge ref_clk) begin
        if (clkOn && dataOp_reg == pbs_pkg::PBS_OP_WRITE
            && laneWr_reg[l]) begin // RULE4 RULE13 RULE17 RULE19
          mem[dataAddr_reg][l*WL +: WL] <=
            {bus.parity_lines[l], bus.dqBus[l*LW +: LW]}; // RULE12
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          rdData_reg[l*LW +: LW] <= '0;
          rdPar_reg[l] <= 1'b0;
        end else if (clkOn && op_reg == pbs_pkg::PBS_OP_READ) begin
          rdData_reg[l*LW +: LW] <= mem[curAddr][l*WL +: LW]; // RULE2 RULE18
          rdPar_reg[l] <= mem[curAddr][l*WL + LW]; // RULE13
        end
      end
    end
  endgenerate

  // drivers float unless a read sits in the data stage
  assign bus.dqDevOe = !bus.outEnable_n // RULE10
    && dataOp_reg == pbs_pkg::PBS_OP_READ; // RULE11 RULE22
  assign bus.dqDev = rdData_reg; // RULE12
  assign bus.parDev = rdPar_reg;
endmodule
`default_nettype wire

// file: design/pbs_sram_ctrl.sv
// memory controller end: turns user requests into sram pin cycles
`timescale 1ns/1ns
`default_nettype none
`include "pbs_regs.svh"
module pbs_sram_ctrl #(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int DATA_W = `PBS_DATA_W,
  parameter int LANES = `PBS_LANES
) (
  input wire logic ref_clk, // core clock
  input wire logic rstn, // sync reset, active low
  input wire logic reqValid, // one access per cycle
  input wire logic reqWrite, // 1 write, 0 read
  input wire logic reqBurst, // 1 advance counter instead of load
  input wire logic [ADDR_W-1:0] reqAddr, // word address
  input wire logic [LANES-1:0] reqLanes, // byte lanes to write
  input wire logic [DATA_W-1:0] reqData, // write data
  input wire logic [LANES-1:0] reqPar, // write parity
  input wire logic hold, // suspend the sram clock
  input wire logic sleep, // sleep request
  input wire logic linear, // 1 linear burst order
  output logic rdValid, // read data valid pulse
  output logic [DATA_W-1:0] rdData, // read data
  output logic [LANES-1:0] rdPar, // read parity
  pbs_if.ctrl bus // sram pins
);
  logic [1:0] wrPipe_reg;
  logic [1:0] rdPipe_reg;
  logic [DATA_W-1:0] wd0_reg, wd1_reg;
  logic [LANES-1:0] wp0_reg, wp1_reg;
  logic lastSel_reg;
  logic pinWr_reg;
  logic pinRd_reg;
  logic [DATA_W-1:0] pinD_reg;
  logic [LANES-1:0] pinP_reg;
  logic loadNow;

  // after a deselect a burst cannot continue, force a load
  assign loadNow = !reqBurst || !lastSel_reg; // RULE9

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bus.addr <= '0;
      bus.clock_qualify_n <= 1'b0;
      bus.select_one_n <= 1'b1;
      bus.select_two <= 1'b0;
      bus.select_three_n <= 1'b1;
      bus.writeEn_n <= 1'b1;
      bus.byte_lane_write_n <= '1;
      bus.advance_or_load <= 1'b0;
      lastSel_reg <= 1'b0;
      pinWr_reg <= 1'b0;
      pinRd_reg <= 1'b0;
      pinD_reg <= '0;
      pinP_reg <= '0;
    end else begin
      bus.clock_qualify_n <= hold; // RULE3
      if (!hold) begin
        bus.addr <= reqAddr;
        bus.select_one_n <= !reqValid; // RULE5
        bus.select_two <= reqValid;
        bus.select_three_n <= !reqValid;
        bus.writeEn_n <= !(reqValid && reqWrite); // RULE7
        bus.byte_lane_write_n <= ~reqLanes; // RULE4
        bus.advance_or_load <= reqValid && !loadNow; // RULE9
        lastSel_reg <= reqValid;
        pinWr_reg <= reqValid && reqWrite;
        pinRd_reg <= reqValid && !reqWrite;
        pinD_reg <= reqData;
        pinP_reg <= reqPar;
      end
    end
  end

  // data phase two qualified edges after the address; the pipe steps
  // only on edges with clock qualify low, which the device also counts outside sleep, so a held clock keeps both aligned
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wrPipe_reg <= 2'h0;
      rdPipe_reg <= 2'h0;
      wd0_reg <= '0;
      wd1_reg <= '0;
      wp0_reg <= '0;
      wp1_reg <= '0;
      bus.dqCtlOe <= 1'b0;
      rdValid <= 1'b0;
      rdData <= '0;
      rdPar <= '0;
    end else begin
      rdValid <= 1'b0;
      if (!bus.clock_qualify_n) begin
        wrPipe_reg <= {wrPipe_reg[0], pinWr_reg};
        rdPipe_reg <= {rdPipe_reg[0], pinRd_reg};
        wd0_reg <= pinD_reg;
        wd1_reg <= wd0_reg;
        wp0_reg <= pinP_reg;
        wp1_reg <= wp0_reg;
        bus.dqCtlOe <= wrPipe_reg[0]; // RULE19
        if (rdPipe_reg[1]) begin
          rdValid <= 1'b1;
          rdData <= bus.dqBus;
          rdPar <= bus.parity_lines;
        end
      end
    end
  end

  assign bus.dqCtl = wd1_reg; // RULE19
  assign bus.parCtl = wp1_reg;
  assign bus.outEnable_n = 1'b0;
  assign bus.sleep_request = sleep;
  assign bus.burstMode = !linear; // RULE14
endmodule
`default_nettype wire

// file: verification/pbs_bus_properties.sv
// pin-level checks between the sram device and its controller
`timescale 1ns/1ns
`default_nettype none
`include "pbs_regs.svh"
module pbs_bus_properties (
  input wire logic ref_clk, // clock
  input wire logic rstn, // reset
  input wire logic clock_qualify_n, // edge qualify
  input wire logic select_one_n, // select one
  input wire logic select_two, // select two
  input wire logic select_three_n, // select three
  input wire logic writeEn_n, // write enable
  input wire logic advance_or_load, // advance or load
  input wire logic outEnable_n, // output enable
  input wire logic dqCtlOe, // ctrl drives
  input wire logic dqDevOe, // device drives
  input wire logic [`PBS_DATA_W-1:0] dqBus // data lines
);
  logic sel;
  assign sel = !select_one_n && select_two && !select_three_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_rd;
    !clock_qualify_n && !advance_or_load && sel && writeEn_n && !outEnable_n;
  endsequence
  sequence s_wr;
    !clock_qualify_n && !advance_or_load && sel && !writeEn_n;
  endsequence
  sequence s_adv;
    !clock_qualify_n && advance_or_load;
  endsequence
  a_read_drives: assert property (
    s_rd ##1 !clock_qualify_n |=> dqDevOe) else $error("read not driven");
  a_burst_read: assert property (
    s_rd ##1 s_adv ##1 !clock_qualify_n |=> dqDevOe)
    else $error("burst read not driven");
  a_write_float: assert property (
    s_wr ##1 !clock_qualify_n |=> dqCtlOe && !dqDevOe)
    else $error("write data phase wrong");
  a_burst_write: assert property (
    s_wr ##1 s_adv ##1 !clock_qualify_n |=> dqCtlOe && !dqDevOe)
    else $error("burst write data phase wrong");
  a_desel_float: assert property (
    (!clock_qualify_n && !advance_or_load && !sel) ##1 !clock_qualify_n
    |=> !dqDevOe) else $error("deselect did not float");
  a_hold_freeze: assert property (
    clock_qualify_n && dqDevOe |=> dqDevOe && $stable(dqBus))
    else $error("output moved while held");
  a_no_clash: assert property (
    !(dqDevOe && dqCtlOe)) else $error("both ends drive");
  a_reset_quiet: assert property (
    $rose(rstn) |-> !dqDevOe && !dqCtlOe) else $error("driver on at reset");
endmodule
`default_nettype wire

// file: verification/pipelined_burst_sram_port_test.sv
// self-checking bench: controller and device joined over the pins
`timescale 1ns/1ns
`default_nettype none
`include "pbs_regs.svh"
module pipelined_burst_sram_port_test;
  logic ref_clk = 1'b0;
  logic rstn, reqValid, reqWrite, reqBurst, hold, sleep, linear, rdValid;
  logic [16:0] reqAddr;
  logic [3:0] reqLanes, reqPar, rdPar;
  logic [31:0] reqData, rdData;
  logic [35:0] mem [int];
  logic [35:0] expQ [$];
  int fail_count = 0;
  int checks_done = 0;
  pbs_if bus ();
  pbs_sram_dev i_pbs_sram_dev (.ref_clk(ref_clk), .rstn(rstn),
    .bus(bus.device));
  pbs_sram_ctrl i_pbs_sram_ctrl (.ref_clk(ref_clk), .rstn(rstn),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqBurst(reqBurst),
    .reqAddr(reqAddr), .reqLanes(reqLanes), .reqData(reqData),
    .reqPar(reqPar), .hold(hold), .sleep(sleep), .linear(linear),
    .rdValid(rdValid), .rdData(rdData), .rdPar(rdPar), .bus(bus.ctrl));
  pbs_bus_properties i_pbs_bus_properties (.ref_clk(ref_clk), .rstn(rstn),
    .clock_qualify_n(bus.clock_qualify_n), .select_one_n(bus.select_one_n),
    .select_two(bus.select_two), .select_three_n(bus.select_three_n),
    .writeEn_n(bus.writeEn_n), .advance_or_load(bus.advance_or_load),
    .outEnable_n(bus.outEnable_n), .dqCtlOe(bus.dqCtlOe),
    .dqDevOe(bus.dqDevOe), .dqBus(bus.dqBus));
  always #4 ref_clk = ~ref_clk;
  task chk(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // parity of lane l rides on data bit 4+l
  task op(input logic w, input logic b, input logic [16:0] a,
    input logic [3:0] ln, input logic [31:0] d);
    logic [35:0] word;
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqBurst <= b;
    reqAddr <= a;
    reqLanes <= ln;
    reqData <= d;
    reqPar <= d[7:4];
    if (w) begin
      word = mem.exists(a) ? mem[a] : 36'hX;
      for (int l = 0; l < 4; l++) if (ln[l]) begin
        word[8*l+:8] = d[8*l+:8];
        word[32+l] = d[4+l];
      end
      mem[a] = word;
    end else expQ.push_back(mem[a]);
  endtask
  task idle(input int n, input logic h);
    repeat (n) begin
      @(posedge ref_clk);
      reqValid <= 1'b0;
      hold <= h;
    end
  endtask
  // gap keeps reads clear of writes still in the pipeline
  task burst(input logic w, input logic lin, input logic [16:0] base);
    logic [16:0] a;
    linear <= lin;
    idle(4, 1'b0);
    for (int k = 0; k < 4; k++) begin
      a = lin ? {base[16:2], base[1:0] + 2'(k)} : base ^ 17'(k);
      op(w, k != 0, a, 4'hF, 32'hB0B0_0000 + 32'(k));
    end
    idle(4, 1'b0);
  endtask
  always @(posedge ref_clk)
    if (rdValid === 1'b1)
      chk({rdPar, rdData}, expQ.size() ? expQ.pop_front() : 36'hX);
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
  initial begin
    {rstn, reqValid, reqWrite, reqBurst, hold, sleep} = 6'h00;
    linear = 1'b1;
    reqAddr = 17'h00000;
    {reqLanes, reqPar, reqData} = 40'h00_0000_0000;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++)
      op(1'b1, 1'b0, 17'h1ABC0 + 17'(i), 4'hF, 32'hC0DE_0000 + 32'(i));
    op(1'b1, 1'b0, 17'h00010, 4'hF, 32'h1234_5678);
    idle(3, 1'b0);
    for (int i = 0; i < 8; i++)
      op(i[0], 1'b0, 17'h1ABC0 + 17'(i), 4'hF, 32'h5A5A_0000 + 32'(i));
    for (int l = 0; l < 4; l++)
      op(1'b1, 1'b0, 17'h00010, 4'(1 << l), 32'h3C5A_96E1 ^ 32'(l * 5));
    idle(4, 1'b0);
    op(1'b0, 1'b0, 17'h00010, 4'h0, 32'h0000_0000);
    burst(1'b1, 1'b1, 17'h1ABC3);
    burst(1'b0, 1'b1, 17'h1ABC2);
    burst(1'b0, 1'b0, 17'h1ABC1);
    op(1'b0, 1'b0, 17'h1ABC4, 4'h0, 32'h0000_0000);
    op(1'b0, 1'b0, 17'h1ABC5, 4'h0, 32'h0000_0000);
    idle(3, 1'b1);
    idle(6, 1'b0);
    sleep <= 1'b1;
    idle(6, 1'b0);
    sleep <= 1'b0;
    idle(6, 1'b0);
    op(1'b0, 1'b0, 17'h1ABC6, 4'h0, 32'h0000_0000);
    op(1'b0, 1'b0, 17'h00010, 4'h0, 32'h0000_0000);
    idle(10, 1'b0);
    chk(36'(expQ.size()), 36'h0);
    end_sim();
  end
endmodule
`default_nettype wire
